// [rtl/mifd_decoder.v]
// Instruction field decoder and one- or two-cycle execution sequencer
// Notes on behaviour
// - Each instruction is one 14-bit word.
// - Byte op, destination clear: result to accumulator.
// - Byte op, destination set: result to file register.
// - Register address is 7 bits, 0 to 127.
// - Bit field picks one of eight bits.
// - Literal is 8 bits, jump target 11.
// - Normally one instruction cycle per instruction.
// - Taken test, jump or return: two cycles, second idles.
// - Instruction cycle is four oscillator periods.
// - Literal don't-care bits never change OPCODE_O; BIT_SEL_O and BIT_MASK_O follow them.
`timescale 1ns/100ps
`include "mifd_defs.vh"
module mifd_decoder (
    // Clock and reset
    input  wire        SYS_CLK_I,
    input  wire        ARST_N_I,
    // Program memory fetch
    input  wire [13:0] INSTR_WORD_I,
    output wire        FETCH_STROBE_O,
    // Datapath feedback
    input  wire        COND_TRUE_I,
    // Decoded fields
    output reg         EXEC_STROBE_O,
    output reg  [1:0]  INSTR_CLASS_O,
    output reg  [3:0]  OPCODE_O,
    output reg  [6:0]  FILE_ADDR_O,
    output reg  [2:0]  BIT_SEL_O,
    output reg  [7:0]  BIT_MASK_O,
    output reg  [7:0]  LITERAL_O,
    output reg  [10:0] JUMP_TARGET_O,
    output reg         WRITE_ACCUM_O,
    output reg         WRITE_FILE_O,
    output reg         PC_LOAD_O,
    output reg         NOP_CYCLE_O,
    output wire [1:0]  PHASE_O
);
    localparam ST_EXEC = 2'b01;
    localparam ST_IDLE = 2'b10;

    reg  [1:0]  phase;
    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [3:0]  next_opcode;
    reg         next_accum;
    reg         next_file;
    reg         next_pc;
    wire [13:0] word;
    wire        take;
    wire        run;
    wire        cycle_end;
    wire [1:0]  cls;

    function [7:0] onehot8;
        input [2:0] sel;
        begin
            onehot8 = 8'h01 << sel;
        end
    endfunction

    function is_cond_op;
        input [13:0] w;
        begin
            is_cond_op = 1'b0;
            if (w[13:12] == `MIFD_CLASS_BYTE) begin
                is_cond_op = (w[11:8] == `MIFD_OP_DECFSZ) || (w[11:8] == `MIFD_OP_INCFSZ);
            end else if (w[13:12] == `MIFD_CLASS_BIT) begin
                is_cond_op = w[11];
            end
        end
    endfunction

    function changes_pc;
        input [13:0] w;
        begin
            changes_pc = (w[13:12] == `MIFD_CLASS_JUMP)
                || (w[13:10] == `MIFD_RETLIT_TOP)
                || (w == `MIFD_WORD_RETURN) || (w == `MIFD_WORD_RETFIE);
        end
    endfunction

    // Bit-select field of a word
    function [2:0] bit_field;
        input [13:0] w;
        begin
            bit_field = w[`MIFD_BITSEL_HI:`MIFD_BITSEL_LO];
        end
    endfunction

    // Opcode with literal don't-care bits cleared
    function [3:0] fold_opcode;
        input [13:0] w;
        begin
            fold_opcode = w[`MIFD_BYTEOP_HI:`MIFD_BYTEOP_LO];
            if (w[13:12] == `MIFD_CLASS_JUMP) begin
                fold_opcode = {3'h0, w[`MIFD_JUMP_GOTO_BIT]};
            end else if (w[13:12] == `MIFD_CLASS_LIT) begin
                if (w[11:10] == 2'h0 || w[11:10] == 2'h1) begin
                    fold_opcode = {w[11:10], 2'h0};
                end else if (w[11:9] == 3'h7 || w[11:9] == 3'h6) begin
                    fold_opcode = {w[11:9], 1'b0};
                end
            end
        end
    endfunction

    // Result goes to the accumulator
    function wants_accum;
        input [13:0] w;
        begin
            case (w[13:12])
                `MIFD_CLASS_BYTE: wants_accum = ~w[`MIFD_DEST_BIT];
                `MIFD_CLASS_LIT:  wants_accum = 1'b1;
                default:          wants_accum = 1'b0;
            endcase
        end
    endfunction

    // Result goes to the file register
    function wants_file;
        input [13:0] w;
        begin
            case (w[13:12])
                `MIFD_CLASS_BYTE: wants_file = w[`MIFD_DEST_BIT];
                `MIFD_CLASS_BIT:  wants_file = ~w[11];
                default:          wants_file = 1'b0;
            endcase
        end
    endfunction

    assign take = (phase == `MIFD_PHASE_FIRST);
    assign run  = take && (state == ST_EXEC);
    assign cycle_end = (phase == `MIFD_PHASE_LAST);
    assign FETCH_STROBE_O = cycle_end;
    assign PHASE_O = phase;
    assign cls = word[`MIFD_CLASS_HI:`MIFD_CLASS_LO];

    mifd_word_reg u_word (
        .clk_i    (SYS_CLK_I),
        .arst_n_i (ARST_N_I),
        .load_i   (cycle_end),
        .word_i   (INSTR_WORD_I),
        .word_o   (word)
    );

    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_EXEC: begin
                if (cycle_end && (changes_pc(word) || (is_cond_op(word) && COND_TRUE_I))) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cycle_end) begin
                    next_state = ST_EXEC;
                end
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
    end

    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Decoded values for the coming instruction cycle
    always @* begin
        next_opcode = fold_opcode(word);
        next_accum  = run && wants_accum(word);
        next_file   = run && wants_file(word);
        next_pc     = run && changes_pc(word);
    end

    // Execute strobe
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            EXEC_STROBE_O <= 1'b0;
        end else begin
            EXEC_STROBE_O <= run;
        end
    end

    // Idle second cycle flag
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            NOP_CYCLE_O <= 1'b1;
        end else if (take) begin
            NOP_CYCLE_O <= (state == ST_IDLE);
        end
    end

    // Instruction class
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            INSTR_CLASS_O <= 2'h0;
        end else if (take) begin
            INSTR_CLASS_O <= cls;
        end
    end

    // Opcode
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            OPCODE_O <= 4'h0;
        end else if (take) begin
            OPCODE_O <= next_opcode;
        end
    end

    // File register address
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            FILE_ADDR_O <= 7'h00;
        end else if (take) begin
            FILE_ADDR_O <= word[`MIFD_FILE_HI:0];
        end
    end

    // Bit select
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            BIT_SEL_O <= 3'h0;
        end else if (take) begin
            BIT_SEL_O <= bit_field(word);
        end
    end

    // Bit mask
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            BIT_MASK_O <= 8'h00;
        end else if (take) begin
            BIT_MASK_O <= onehot8(bit_field(word));
        end
    end

    // Literal
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            LITERAL_O <= 8'h00;
        end else if (take) begin
            LITERAL_O <= word[7:0];
        end
    end

    // Jump target
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            JUMP_TARGET_O <= 11'h000;
        end else if (take) begin
            JUMP_TARGET_O <= word[10:0];
        end
    end

    // Accumulator write pulse
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            WRITE_ACCUM_O <= 1'b0;
        end else begin
            WRITE_ACCUM_O <= next_accum;
        end
    end

    // File write pulse
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            WRITE_FILE_O <= 1'b0;
        end else begin
            WRITE_FILE_O <= next_file;
        end
    end

    // Program counter load pulse
    always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PC_LOAD_O <= 1'b0;
        end else begin
            PC_LOAD_O <= next_pc;
        end
    end
endmodule // mifd_decoder

// [rtl/mifd_defs.vh]
// Field positions, class codes and timing counts for the instruction field decoder
`ifndef MIFD_DEFS_VH
`define MIFD_DEFS_VH
`define MIFD_WORD_W        14
`define MIFD_CLASS_HI      13
`define MIFD_CLASS_LO      12
`define MIFD_CLASS_BYTE    2'h0
`define MIFD_CLASS_BIT     2'h1
`define MIFD_CLASS_JUMP    2'h2
`define MIFD_CLASS_LIT     2'h3
`define MIFD_DEST_BIT      7
`define MIFD_FILE_HI       6
`define MIFD_BITSEL_HI     9
`define MIFD_BITSEL_LO     7
`define MIFD_BYTEOP_HI     11
`define MIFD_BYTEOP_LO     8
`define MIFD_LITOP_HI      11
`define MIFD_LITOP_LO      8
`define MIFD_JUMP_GOTO_BIT 11
`define MIFD_PHASES        4
`define MIFD_PHASE_LAST    2'h3
`define MIFD_PHASE_FIRST   2'h0
`define MIFD_RETLIT_TOP    4'hD
`define MIFD_OP_DECFSZ     4'hB
`define MIFD_OP_INCFSZ     4'hF
`define MIFD_WORD_RETURN   14'h0008
`define MIFD_WORD_RETFIE   14'h0009
`define MIFD_NOP_WORD      14'h0000
`endif

// [rtl/mifd_word_reg.v]
// Instruction word holding register with registered read data
`timescale 1ns/100ps
module mifd_word_reg (
    // Clock and reset
    input  wire        clk_i,
    input  wire        arst_n_i,
    // Write side
    input  wire        load_i,
    input  wire [13:0] word_i,
    // Read side
    output reg  [13:0] word_o
);
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            word_o <= 14'h0000;
        end else if (load_i) begin
            word_o <= word_i;
        end
    end
endmodule // mifd_word_reg

// [tb/mifd_decoder_asserts.sv]
// Assertion checker for the instruction field decoder
`timescale 1ns/100ps
module mifd_decoder_asserts (
    input wire        SYS_CLK_I,
    input wire        ARST_N_I,
    input wire [13:0] INSTR_WORD_I,
    input wire        FETCH_STROBE_O,
    input wire        EXEC_STROBE_O,
    input wire [1:0]  INSTR_CLASS_O,
    input wire [6:0]  FILE_ADDR_O,
    input wire [7:0]  BIT_MASK_O,
    input wire [7:0]  LITERAL_O,
    input wire [10:0] JUMP_TARGET_O,
    input wire        WRITE_ACCUM_O,
    input wire        WRITE_FILE_O,
    input wire        PC_LOAD_O,
    input wire        NOP_CYCLE_O,
    input wire [1:0]  PHASE_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    wire       ex = EXEC_STROBE_O;
    wire [1:0] c  = INSTR_CLASS_O;
    reg [13:0] lat;
    // Copy of the word taken at the fetch edge
    always @(posedge SYS_CLK_I or negedge ARST_N_I)
        if (!ARST_N_I) lat <= 14'h0000;
        else if (PHASE_O == 2'h3) lat <= INSTR_WORD_I;
    phase_step_a: assert property ($past(ARST_N_I) |-> PHASE_O == $past(PHASE_O) + 2'h1)
        else $error("phase did not advance by one");
    fetch_phase_a: assert property (FETCH_STROBE_O == (PHASE_O == 2'h3))
        else $error("fetch strobe off phase three");
    exec_phase_a: assert property (ex |-> PHASE_O == 2'h1 && !NOP_CYCLE_O)
        else $error("execute strobe off phase one");
    field_split_a: assert property (ex |-> c == lat[13:12] && FILE_ADDR_O == lat[6:0]
        && LITERAL_O == lat[7:0])
        else $error("class or field differs from fetched word");
    dest_select_a: assert property (ex && c == 2'h0 && lat[11:8] != 4'h0
        |-> WRITE_ACCUM_O != lat[7] && WRITE_FILE_O == lat[7])
        else $error("destination select not honoured");
    bit_mask_a: assert property (ex && c == 2'h1 |-> BIT_MASK_O == 8'h01 << lat[9:7])
        else $error("bit mask wrong");
    jump_target_a: assert property (ex && c == 2'h2
        |-> JUMP_TARGET_O == lat[10:0] && PC_LOAD_O)
        else $error("jump target or load wrong");
    jump_idle_a: assert property (ex && c == 2'h2 |-> ##4 NOP_CYCLE_O && !ex)
        else $error("jump not followed by idle cycle");
    literal_single_a: assert property (ex && c == 2'h3 && lat[11:10] != 2'h1 |-> ##4 ex)
        else $error("literal op took two cycles");
    cover property (ex && c == 2'h1);
    cover property (ex && c == 2'h2);
    cover property (NOP_CYCLE_O && PHASE_O == 2'h1);
endmodule // mifd_decoder_asserts
bind mifd_decoder mifd_decoder_asserts mifd_decoder_asserts_i (.*);

// [tb/mifd_decoder_bench.sv]
// Self-checking bench for the instruction field decoder
`timescale 1ns/100ps
module mifd_decoder_bench;
    reg         clk, arst_n, nc, idle, two;
    reg  [13:0] nw, cur;
    reg  [31:0] r;
    reg  [1:0]  c;
    wire [13:0] word;
    wire        cond, fs, ex, wa, wf, pl, nop;
    wire [1:0]  cls, ph;
    wire [2:0]  bs;
    wire [3:0]  op;
    wire [6:0]  fa;
    wire [7:0]  mask, lit;
    wire [10:0] jt;
    integer     n_mismatch, samples_checked;
    integer     q[$];
    mifd_prog_mem mifd_prog_mem_i (.clk_i(clk), .fetch_i(fs), .next_word_i(nw),
        .next_cond_i(nc), .word_o(word), .cond_o(cond));
    mifd_decoder mifd_decoder_i (.SYS_CLK_I(clk), .ARST_N_I(arst_n), .INSTR_WORD_I(word),
        .FETCH_STROBE_O(fs), .COND_TRUE_I(cond), .EXEC_STROBE_O(ex), .INSTR_CLASS_O(cls),
        .OPCODE_O(op), .FILE_ADDR_O(fa), .BIT_SEL_O(bs), .BIT_MASK_O(mask), .LITERAL_O(lit),
        .JUMP_TARGET_O(jt), .WRITE_ACCUM_O(wa), .WRITE_FILE_O(wf), .PC_LOAD_O(pl),
        .NOP_CYCLE_O(nop), .PHASE_O(ph));
    task chk(input [15:0] s, input [15:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (s !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        final_report;
    end
    initial begin
        arst_n = 1'b0;
        nw = 14'h0000;
        nc = 1'b0;
        idle = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        q.push_back(0);
        r = $urandom(37);
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (1200) @(negedge clk);
        final_report;
    end
    // Model: pop at phase one, choose next word and test outcome at phase two
    always @(negedge clk) if (arst_n) begin
        if (ph == 2'h1) begin
            cur = q.pop_front();
            c = cur[13:12];
            if (idle) begin
                chk(nop, 1'b1);
                chk(ex, 1'b0);
            end else begin
                chk(ex, 1'b1);
                chk(nop, 1'b0);
                chk(bs, cur[9:7]);
                chk(op, c == 2'h2 ? {3'h0, cur[11]} : (c == 2'h3 && !cur[11]) ? {cur[11:10], 2'h0}
                    : (c == 2'h3 && cur[10]) ? {cur[11:9], 1'b0} : cur[11:8]);
                chk(cls, c);
                chk(fa, cur[6:0]);
                chk(lit, cur[7:0]);
                chk(jt, cur[10:0]);
                chk(mask, 8'h01 << cur[9:7]);
                chk(wa, (c == 2'h0 && !cur[7]) || c == 2'h3);
                chk(wf, (c == 2'h0 && cur[7]) || (c == 2'h1 && !cur[11]));
                chk(pl, c == 2'h2 || cur[13:10] == 4'hD);
            end
        end
        if (ph == 2'h2) begin
            r = $urandom;
            nw = r[13:0];
            if (nw[13:8] == 6'h00) nw[13] = 1'b1;
            nc = r[20];
            two = !idle && (c == 2'h2 || cur[13:10] == 4'hD || nc && ((c == 2'h0
                && cur[11] && cur[9:8] == 2'h3) || (c == 2'h1 && cur[11])));
            idle = two;
            q.push_back(nw);
        end
    end
endmodule // mifd_decoder_bench

// [tb/mifd_prog_mem.sv]
// Program memory model presenting one word per fetch strobe
`timescale 1ns/100ps
module mifd_prog_mem (
    // Clock and fetch request
    input  wire        clk_i,
    input  wire        fetch_i,
    // Word and test outcome chosen by the bench
    input  wire [13:0] next_word_i,
    input  wire        next_cond_i,
    // Lines toward the decoder
    output reg  [13:0] word_o = 14'h0000,
    output reg         cond_o = 1'b0
);
    // Outside a fetch the lines carry a changing pattern
    always @(negedge clk_i) begin
        word_o <= fetch_i ? next_word_i : ~word_o;
        cond_o <= fetch_i ? next_cond_i : ~cond_o;
    end
endmodule // mifd_prog_mem
